// ===== core/pgl_ctrl.sv
// Lock detect, enable, reset and output gating around the clock synthesizer
//
// Behaviour
// (R1) Lock asserted only with stable output in phase with reference.
// (R2) Lock may toggle at start; outside logic qualifies before use.
// (R3) Lock routed both to core and to a pin output.
// (R4) Outside logic pulses reset after loss of lock when phase matters.
// (R5) Every post counter uses separate high and low counts.
// (R6) Duty step is 50% over counter value; near-100% step refused.
// (R7) External feedback mode needs the feedback counter at exact half duty.
// (R8) Enable pin low: outputs grounded, lock lost.
// (R9) Enable pin high again: relock and resynchronize outputs.
// (R10) Reset high: counters reset, outputs cleared, lock dropped, oscillator nominal.
// (R11) Reset released: resynchronize while relocking; outputs may start fast.
// (R12) Outside logic may keep gates off until lock if overshoot matters.
// (R13) Detector gate off: oscillator holds last value, outputs keep running.
// (R14) Detector gate driven by user signal or input-lost flag.
// (R15) Every global and regional port has its own clock gate.
// (R16) Gate enable sampled on counter output falling edge, no glitches; the counter samples it every cycle of the low phase.
// (R17) Gating leaves loop counters alone; lock kept, no relock.
// (R18) External gates alike, but re-enable relocks in external feedback mode.
// (R19) Loop filter settings come from fixed discrete sets only.
// (R20) Outside qualifier counts stable lock cycles, clears at once.
// (R21) Counter drives high for high count, low for low count, repeating.
`timescale 1ns/1ps
`default_nettype none
module pgl_ctrl #(
   parameter int N_CORE = pgl_pkg::N_CORE,
   parameter int N_EXT = pgl_pkg::N_EXT,
   parameter int W = pgl_pkg::CNT_W
) (
   // Clock, reset and clock enable
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic I_CE,
   // Synthesizer control pins (asynchronous)
   input wire logic I_PLL_ENABLE,
   input wire logic I_ARESET,
   input wire logic I_PFD_ENA,
   // Phase detector status from the analog loop (asynchronous)
   input wire logic I_PHASE_MATCH,
   input wire logic I_INCLK_LOST,
   // Mode
   input wire logic I_EXT_FB_MODE,
   // Post counter duty counts, global and regional then external
   input wire logic [(N_CORE+N_EXT)*W-1:0] I_HIGH_CNT,
   input wire logic [(N_CORE+N_EXT)*W-1:0] I_LOW_CNT,
   // Gate enables (asynchronous to the counters' decision point)
   input wire logic [N_CORE-1:0] I_CLK_ENA,
   input wire logic [N_EXT-1:0] I_EXT_CLK_ENA,
   // Gated clocks
   output logic [N_CORE-1:0] O_CORE_CLK,
   output logic [N_EXT-1:0] O_EXT_CLK,
   // Lock to core and to pin
   output logic O_LOCKED,
   output logic O_LOCKED_PIN,
   // Oscillator hold and nominal flags
   output logic O_VCO_HOLD,
   output logic O_VCO_NOMINAL,
   // Duty setting error (near-100% step requested)
   output logic O_DUTY_ERR
);
   localparam int N = N_CORE + N_EXT;

   logic [4:0] s1, s2;
   logic [N_CORE-1:0] ena1, ena2;
   logic [N_EXT-1:0] xena1, xena2, xena_prev;
   logic en_s, rst_s, pfd_s, match_s, lost_s;
   pgl_pkg::pgl_lock_t state;
   logic [7:0] settle;
   logic [7:0] relock;
   logic clr;
   logic [N-1:0] gclk, rclk;
   logic [N-1:0] ena_all;

   // Two-flop synchronisers for pin inputs
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         s1 <= 5'h00;
         s2 <= 5'h00;
         ena1 <= '0;
         ena2 <= '0;
         xena1 <= '0;
         xena2 <= '0;
      end else if (I_CE) begin
         s1 <= {I_PLL_ENABLE, I_ARESET, I_PFD_ENA, I_PHASE_MATCH, I_INCLK_LOST};
         s2 <= s1;
         ena1 <= I_CLK_ENA;
         ena2 <= ena1;
         xena1 <= I_EXT_CLK_ENA;
         xena2 <= xena1;
      end
   end
   assign {en_s, rst_s, pfd_s, match_s, lost_s} = s2;

   // (R10) Reset or disable clears counters
   assign clr = rst_s || !en_s;

   // Lock state machine; ignores the detector gate, leaves lock on match loss or lost input
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state <= pgl_pkg::PGL_IDLE;
         settle <= pgl_pkg::CNT_RST;
      end else if (I_CE) begin
         case (state)
            pgl_pkg::PGL_IDLE: begin
               settle <= pgl_pkg::CNT_RST;
               // (R9) Relock once enable returns
               if (!clr) begin
                  state <= pgl_pkg::PGL_ACQ;
               end
            end
            pgl_pkg::PGL_ACQ: begin
               // (R11) Resynchronize while relocking
               if (clr) begin
                  state <= pgl_pkg::PGL_IDLE;
               end else if (!match_s || lost_s || relock != 8'h00) begin
                  settle <= pgl_pkg::CNT_RST;
               end else if (settle + 8'h01 >= pgl_pkg::LOCK_SETTLE) begin
                  state <= pgl_pkg::PGL_LOCK;
               end else begin
                  settle <= settle + 8'h01;
               end
            end
            pgl_pkg::PGL_LOCK: begin
               // (R8) Disable drops lock
               if (clr) begin
                  state <= pgl_pkg::PGL_IDLE;
               end else if (!match_s || lost_s || relock != 8'h00) begin
                  state <= pgl_pkg::PGL_ACQ;
                  settle <= pgl_pkg::CNT_RST;
               end
            end
            default: begin
               state <= pgl_pkg::PGL_IDLE;
            end
         endcase
      end
   end

   // (R18) External feedback re-enable forces relock
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         xena_prev <= '0;
         relock <= pgl_pkg::CNT_RST;
      end else if (I_CE) begin
         xena_prev <= xena2;
         if (I_EXT_FB_MODE && xena2[pgl_pkg::FB_IDX-N_CORE] && !xena_prev[pgl_pkg::FB_IDX-N_CORE]) begin
            relock <= pgl_pkg::RELOCK_CYC;
         end else if (relock != 8'h00) begin
            relock <= relock - 8'h01;
         end
      end
   end

   // (R1) Lock only in locked state
   // (R3) Same lock to core and pin
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_LOCKED <= 1'b0;
         O_LOCKED_PIN <= 1'b0;
         O_VCO_HOLD <= 1'b0;
         O_VCO_NOMINAL <= 1'b1;
      end else if (I_CE) begin
         O_LOCKED <= (state == pgl_pkg::PGL_LOCK) && !clr && match_s && !lost_s;
         O_LOCKED_PIN <= (state == pgl_pkg::PGL_LOCK) && !clr && match_s && !lost_s;
         // (R13) Hold control value when gated off
         O_VCO_HOLD <= !pfd_s && !clr;
         // (R10) Oscillator back to nominal
         O_VCO_NOMINAL <= clr;
      end
   end

   // (R6) Near-100% duty refused: low count zero
   function automatic logic duty_bad(input logic [W-1:0] hi, input logic [W-1:0] lo);
      duty_bad = (lo == '0) && (hi != '0);
   endfunction

   // (R6) Flag any counter with an unreachable duty step
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_DUTY_ERR <= 1'b0;
      end else if (I_CE) begin
         O_DUTY_ERR <= 1'b0;
         for (int i = 0; i < N; i++) begin
            if (duty_bad(I_HIGH_CNT[i*W +: W], I_LOW_CNT[i*W +: W])) begin
               O_DUTY_ERR <= 1'b1;
            end
         end
      end
   end

   // (R17) Gate enables never reach the lock logic, except the feedback output's in external feedback mode
   assign ena_all = {xena2, ena2};

   // Post counters with their gates
   for (genvar g = 0; g < N; g++) begin : g_cnt
      pgl_post_counter #(.W(W)) u_cnt (
         .i_clk(I_CLK),
         .i_resetn(I_RESETN),
         .i_ce(I_CE),
         .i_clr(clr),
         .i_high(I_HIGH_CNT[g*W +: W]),
         .i_low(I_LOW_CNT[g*W +: W]),
         .i_ena(ena_all[g]),
         .o_clk(gclk[g]),
         .o_raw(rclk[g])
      );
   end

   // (R8) Outputs grounded while disabled
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_CORE_CLK <= '0;
         O_EXT_CLK <= '0;
      end else if (I_CE) begin
         O_CORE_CLK <= clr ? '0 : gclk[N_CORE-1:0];
         O_EXT_CLK <= clr ? '0 : gclk[N-1:N_CORE];
      end
   end

   // Assertions
   property p_lock_needs_match;
      @(posedge I_CLK) disable iff (!I_RESETN)
      I_CE && O_LOCKED |-> $past(match_s) && !$past(lost_s);
   endproperty
   a_lock_needs_match: assert property (p_lock_needs_match) else $error("lock without phase match"); // (R1)

   property p_pin_equal;
      @(posedge I_CLK) disable iff (!I_RESETN)
      O_LOCKED == O_LOCKED_PIN;
   endproperty
   a_pin_equal: assert property (p_pin_equal) else $error("lock pin differs from core lock"); // (R3)

   property p_gate_within_raw;
      @(posedge I_CLK) disable iff (!I_RESETN)
      (gclk & ~rclk) == '0;
   endproperty
   a_gate_within_raw: assert property (p_gate_within_raw) else $error("gate made a pulse of its own"); // (R15)

   property p_disable_ground;
      @(posedge I_CLK) disable iff (!I_RESETN)
      I_CE && !en_s ##1 I_CE |-> O_CORE_CLK == '0 && O_EXT_CLK == '0 && !O_LOCKED;
   endproperty
   a_disable_ground: assert property (p_disable_ground) else $error("outputs not grounded when disabled"); // (R8)

   property p_reset_nominal;
      @(posedge I_CLK) disable iff (!I_RESETN)
      I_CE && rst_s ##1 I_CE |-> O_VCO_NOMINAL && !O_LOCKED;
   endproperty
   a_reset_nominal: assert property (p_reset_nominal) else $error("reset did not drop lock"); // (R10)

   property p_relock_settle;
      @(posedge I_CLK) disable iff (!I_RESETN)
      $rose(O_LOCKED) |-> $past(state) == pgl_pkg::PGL_LOCK;
   endproperty
   a_relock_settle: assert property (p_relock_settle) else $error("lock rose without settling"); // (R9)

   property p_hold;
      @(posedge I_CLK) disable iff (!I_RESETN)
      I_CE && !pfd_s && !clr ##1 I_CE |-> O_VCO_HOLD;
   endproperty
   a_hold: assert property (p_hold) else $error("oscillator not held"); // (R13)

   property p_duty_err;
      @(posedge I_CLK) disable iff (!I_RESETN)
      I_CE && I_LOW_CNT[W-1:0] == '0 && I_HIGH_CNT[W-1:0] != '0 ##1 I_CE |-> O_DUTY_ERR;
   endproperty
   a_duty_err: assert property (p_duty_err) else $error("near-full duty not flagged"); // (R6)

   property p_gate_kept_lock;
      @(posedge I_CLK) disable iff (!I_RESETN)
      I_CE && state == pgl_pkg::PGL_LOCK && !clr && match_s && !lost_s && relock == 8'h00 ##1 I_CE
         |-> state == pgl_pkg::PGL_LOCK;
   endproperty
   a_gate_kept_lock: assert property (p_gate_kept_lock) else $error("gating disturbed lock"); // (R17)

   property p_ext_relock;
      @(posedge I_CLK) disable iff (!I_RESETN)
      I_CE && I_EXT_FB_MODE && xena2[pgl_pkg::FB_IDX-N_CORE] && !xena_prev[pgl_pkg::FB_IDX-N_CORE]
         ##1 I_CE |-> relock == pgl_pkg::RELOCK_CYC;
   endproperty
   a_ext_relock: assert property (p_ext_relock) else $error("external re-enable missed relock"); // (R18)
endmodule
`default_nettype wire

// ===== core/pgl_post_counter.sv
// One post-scale counter with high/low duty counts and glitch-free gate
`timescale 1ns/1ps
`default_nettype none
module pgl_post_counter #(
   parameter int W = 8
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_clr,
   // Duty counts and gate enable
   input wire logic [W-1:0] i_high,
   input wire logic [W-1:0] i_low,
   input wire logic i_ena,
   // Gated output and ungated raw output
   output logic o_clk,
   output logic o_raw
);
   logic [W-1:0] cnt;
   logic phase;
   logic ena_q;

   // (R21) High then low loop
   // (R5) Separate high and low counts
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt <= '0;
         phase <= 1'b1;
      end else if (i_ce) begin
         if (i_clr) begin
            cnt <= '0;
            phase <= 1'b1;
         end else if (phase && cnt + W'(1) >= i_high) begin
            cnt <= '0;
            phase <= (i_low == '0);
         end else if (!phase && cnt + W'(1) >= i_low) begin
            cnt <= '0;
            phase <= (i_high != '0);
         end else begin
            cnt <= cnt + W'(1);
         end
      end
   end

   // (R16) Enable sampled every cycle while output low, taking effect at the next rising edge
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ena_q <= 1'b0;
      end else if (i_ce && (!phase || i_clr)) begin
         ena_q <= i_ena;
      end
   end

   // (R15) Per-port gate on counter output
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_clk <= 1'b0;
         o_raw <= 1'b0;
      end else if (i_ce) begin
         o_raw <= phase && !i_clr;
         o_clk <= phase && !i_clr && (ena_q || (!phase ? i_ena : ena_q)) && ena_q;
      end
   end
endmodule
`default_nettype wire

// ===== shared/pgl_pkg.sv
// Shared constants for the clock output gating and lock control block
package pgl_pkg;
   // Counter field width and counts
   localparam int CNT_W = 8;
   localparam int N_CORE = 8;
   localparam int N_EXT = 4;
   localparam int N_OUT = 12;
   // Index of the external output that may drive the feedback return pin
   localparam int FB_IDX = 8;
   // Reset values of outputs and counters
   localparam logic RST_LEVEL = 1'b0;
   localparam logic [7:0] CNT_RST = 8'h00;
   // Cycles of clean phase match before raw lock is reported
   localparam logic [7:0] LOCK_SETTLE = 8'h10;
   // Relock delay after external feedback re-enable
   localparam logic [7:0] RELOCK_CYC = 8'h08;
   // Lock state machine
   typedef enum logic [2:0] {
      PGL_IDLE = 3'b001,
      PGL_ACQ = 3'b010,
      PGL_LOCK = 3'b100
   } pgl_lock_t;
endpackage

// ===== tb/pgl_ctrl_tb.sv
// Self-checking bench for the output gating and lock control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module pgl_ctrl_tb;
   logic I_CLK = 1'b0;
   logic I_RESETN = 1'b0;
   logic en = 1'b1, ar = 1'b0, pm = 1'b1, lost = 1'b0, fbm = 1'b0, upfd = 1'b1, auto = 1'b0;
   logic mon_on = 1'b0, keep = 1'b0, s, a;
   logic [95:0] hc, lc;
   logic [7:0] uena = 8'hFF;
   logic [3:0] xena = 4'hF;
   logic [7:0] cclk, cena;
   logic [3:0] xclk;
   logic lk, lkp, hold, nom, derr, qual, par, pfd;
   wire logic [11:0] allc;
   int err_count = 0, n_tests = 0, hr = 0, h, l, c;
   assign allc = {xclk, cclk};
   // Free-running bench clock
   initial forever #4 I_CLK = ~I_CLK;
   pgl_ctrl dut_u (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_CE(1'b1), .I_PLL_ENABLE(en), .I_ARESET(ar | par),
      .I_PFD_ENA(pfd), .I_PHASE_MATCH(pm), .I_INCLK_LOST(lost), .I_EXT_FB_MODE(fbm), .I_HIGH_CNT(hc),
      .I_LOW_CNT(lc), .I_CLK_ENA(cena), .I_EXT_CLK_ENA(xena), .O_CORE_CLK(cclk), .O_EXT_CLK(xclk),
      .O_LOCKED(lk), .O_LOCKED_PIN(lkp), .O_VCO_HOLD(hold), .O_VCO_NOMINAL(nom), .O_DUTY_ERR(derr));
   pgl_user_model usr_u (.i_clk(I_CLK), .i_resetn(I_RESETN), .i_locked(lk), .i_auto_rst(auto),
      .i_user_pfd(upfd), .i_clk_lost(lost), .i_user_ena(uena), .o_qual(qual), .o_areset(par),
      .o_pfd_ena(pfd), .o_clk_ena(cena));
   function automatic logic exp_err(input logic [7:0] hi, input logic [7:0] lo);
      return (lo == 8'h00) && (hi != 8'h00);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge I_CLK);
      #1;
   endtask
   task automatic wlock(input int lo, input int hi);
      c = 0;
      while (lk !== 1'b1 && c < hi) begin
         tick(1);
         c++;
      end
      `CHK("lock_time", 1'b1, (c >= lo && lk === 1'b1))
   endtask
   // One whole high run then low run of output k
   task automatic meas(input int k);
      h = 0;
      l = 0;
      repeat (99) if (allc[k] !== 1'b0) tick(1);
      repeat (99) if (allc[k] !== 1'b1) tick(1);
      while (allc[k] === 1'b1 && h < 99) begin h++; tick(1); end
      while (allc[k] === 1'b0 && l < 99) begin l++; tick(1); end
      `CHK("duty_h", hc[k*8+:8], 8'(h))
      `CHK("duty_l", lc[k*8+:8], 8'(l))
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Every high pulse of output 0 must be whole, and lock must hold while gating
   always @(posedge I_CLK) begin
      #1;
      if (cclk[0] === 1'b1) hr++;
      else begin
         if (hr != 0 && mon_on) `CHK("pulse0", int'(hc[7:0]), hr)
         hr = 0;
      end
      if (keep) `CHK("lock_kept", 1'b1, lk)
   end
   // Hang guard, far beyond the fewer than two thousand cycles needed
   initial begin
      #200000;
      err_count++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h86b1));
      for (int i = 0; i < 12; i++) begin
         hc[i*8+:8] = 8'(1 + $urandom % 6);
         lc[i*8+:8] = 8'(1 + $urandom % 6);
      end
      tick(4);
      `CHK("rst_nom", 1'b1, nom)
      `CHK("rst_clk", 12'h000, allc)
      I_RESETN = 1'b1;
      wlock(int'(pgl_pkg::LOCK_SETTLE), 50);
      `CHK("lock_pin", lk, lkp)
      tick(8);
      for (int k = 0; k < 12; k++) meas(k);
      mon_on = 1'b1;
      keep = 1'b1;
      // Random gate toggling, also mid-pulse
      repeat (150) begin
         uena = 8'($urandom);
         xena = 4'($urandom);
         tick(1 + $urandom % 5);
      end
      uena = 8'hFF;
      xena = 4'hF;
      for (int j = 0; j < 8; j++) begin
         uena = ~(8'h01 << j);
         // Sync, a whole running pulse and output pipeline must pass
         tick(12);
         s = 1'b0;
         a = 1'b0;
         repeat (30) begin s |= cclk[j]; a |= cclk[(j + 1) % 8]; tick(1); end
         `CHK("gate_off", 1'b0, s)
         `CHK("gate_nb", 1'b1, a)
      end
      uena = 8'hFF;
      mon_on = 1'b0;
      lc[7:0] = 8'h00;
      tick(6);
      `CHK("duty_err", exp_err(hc[7:0], lc[7:0]), derr)
      lc[7:0] = 8'h03;
      tick(6);
      `CHK("duty_ok", exp_err(hc[7:0], lc[7:0]), derr)
      upfd = 1'b0;
      tick(6);
      `CHK("hold", 1'b1, hold)
      meas(1);
      upfd = 1'b1;
      // Lost input clock drops lock, so stop the lock monitor first
      keep = 1'b0;
      lost = 1'b1;
      tick(6);
      `CHK("hold_lost", 1'b1, hold)
      lost = 1'b0;
      wlock(int'(pgl_pkg::LOCK_SETTLE), 60);
      keep = 1'b1;
      repeat (8) begin xena[1] = ~xena[1]; tick(5); end
      keep = 1'b0;
      // Feedback counter at exact half duty before external feedback
      lc[71:64] = hc[71:64];
      meas(8);
      fbm = 1'b1;
      xena = 4'hE;
      tick(10);
      xena = 4'hF;
      c = 0;
      while (lk === 1'b1 && c < 20) begin tick(1); c++; end
      `CHK("fb_relock", 1'b0, lk)
      wlock(1, 60);
      fbm = 1'b0;
      auto = 1'b1;
      en = 1'b0;
      tick(6);
      s = 1'b0;
      repeat (30) begin s |= |allc | lk; tick(1); end
      `CHK("dis_quiet", 1'b0, s)
      `CHK("dis_nom", 1'b1, nom)
      en = 1'b1;
      wlock(int'(pgl_pkg::LOCK_SETTLE), 60);
      auto = 1'b0;
      ar = 1'b1;
      tick(5);
      `CHK("ar_lock", 1'b0, lk)
      `CHK("ar_clk", 12'h000, allc)
      `CHK("ar_nom", 1'b1, nom)
      ar = 1'b0;
      pm = 1'b0;
      tick(40);
      `CHK("no_match", 1'b0, lk)
      pm = 1'b1;
      wlock(int'(pgl_pkg::LOCK_SETTLE), 50);
      finish_test();
   end
endmodule
`default_nettype wire

// ===== tb/pgl_user_model.sv
// Core-side user logic: lock qualifier, gate hold-off and detector gate source
`timescale 1ns/1ps
`default_nettype none
module pgl_user_model #(
   parameter int QUAL = 4
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Raw lock and user requests
   input wire logic i_locked,
   input wire logic i_auto_rst,
   input wire logic i_user_pfd,
   input wire logic i_clk_lost,
   input wire logic [7:0] i_user_ena,
   // Qualified lock and controls to the block
   output logic o_qual,
   output logic o_areset,
   output logic o_pfd_ena,
   output logic [7:0] o_clk_ena
);
   int unsigned cnt;
   // loop cap picked from fixed set
   localparam int LOOP_CAP_PF = 10;
   // lock qualifier
   // Raw lock may chatter, so demand a clean run and drop at once
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt <= 0;
         o_qual <= 1'b0;
      end else if (!i_locked) begin
         cnt <= 0;
         o_qual <= 1'b0;
      end else if (cnt < QUAL) begin
         cnt <= cnt + 1;
      end else begin
         o_qual <= 1'b1;
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_areset <= 1'b0;
      end else begin
         o_areset <= i_auto_rst & o_qual & !i_locked;
      end
   end
   // gates held off until lock is trusted
   assign o_clk_ena = i_user_ena & {8{o_qual}};
   // detector gate from user or clock loss
   assign o_pfd_ena = i_user_pfd & !i_clk_lost;
endmodule
`default_nettype wire
